//--- rtl/long_shift_count_unit.sv
module long_shift_count_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request from the execution pipeline
    input wire logic reqValid,
    output logic reqReady,
    input wire lsc_pkg::lsc_req_t req,
    // result towards register file and status
    output logic resValid,
    input wire logic resReady,
    output lsc_pkg::lsc_res_t res,
    // sticky overflow-trap in processor status
    input wire logic trapClear,
    output logic trapSticky
);
    import lsc_pkg::*;

    // decode stage state
    logic decValid_r;
    logic decValid_nxt;
    lsc_dec_t dec_r;
    lsc_dec_t dec_nxt;
    // result stage state
    logic resValid_r;
    logic resValid_nxt;
    lsc_res_t res_r;
    lsc_res_t res_nxt;
    // sticky trap state
    logic trap_r;
    logic trap_nxt;

    // handshake terms
    logic resFree;
    logic decFree;
    logic decMove;
    logic resLoad;

    // shifter and decode datapath
    logic [WIDTH-1:0] shifted;
    logic [WIDTH-1:0] resultData;
    lsc_dec_t decIn;

    // count classification
    logic countFull;
    logic countOvf;
    logic countUnsafe;
    logic [AMT_W-1:0] countAmount;

    // result fields before they are registered
    logic resultZero;
    lsc_res_t resIn;

    // sticky trap events
    logic trapSet;
    logic trapClr;

    // pipeline back-pressure: each stage accepts when empty or draining
    assign resFree = !resValid_r || resReady;
    assign decFree = !decValid_r || resFree;
    assign reqReady = decFree;

    // transfers into the decode and result stages
    assign decMove = reqValid && decFree;
    assign resLoad = decValid_r && resFree;

    // classify the incoming count
    assign countFull = (req.count == FULL_COUNT);
    assign countOvf = req.count[OVF_BIT];
    assign countUnsafe = (req.count > MAX_SAFE_COUNT);

    // top three count bits drop out; the full-sequence count moves nothing
    always_comb begin
        countAmount = req.count[AMT_W-1:0];
        if (countFull) begin
            countAmount = AMT_ZERO;
        end
    end

    // decoded request as it enters the decode stage
    always_comb begin
        decIn = '0;
        decIn.dir = req.dir;
        decIn.operand = req.operand;
        decIn.amount = countAmount;
        decIn.bypass = countFull;
        decIn.ovf = countOvf;
        decIn.unsafe = countUnsafe;
    end

    // decode valid next: a take fills the slot, a move onward empties it
    always_comb begin
        decValid_nxt = decValid_r;
        if (decMove) begin
            decValid_nxt = 1'b1;
        end else if (resLoad) begin
            decValid_nxt = 1'b0;
        end
    end

    // decode valid register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            decValid_r <= 1'b0;
        end else begin
            decValid_r <= decValid_nxt;
        end
    end

    // decode payload next: a taken request replaces the held one
    always_comb begin
        dec_nxt = dec_r;
        if (decMove) begin
            dec_nxt = decIn;
        end
    end

    // decode payload register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    // shift the decoded operand
    lsc_barrel uBarrel (
        .dir(dec_r.dir),
        .dataIn(dec_r.operand),
        .amount(dec_r.amount),
        .dataOut(shifted)
    );

    // net effect of the full sequence is the untouched operand
    assign resultData = dec_r.bypass ? dec_r.operand : shifted;

    // zero indication of the delivered data
    assign resultZero = (resultData == DATA_RST);

    // result fields as they enter the result stage
    always_comb begin
        resIn = '0;
        resIn.data = resultData;
        resIn.ovf = dec_r.ovf;
        resIn.ovfTrap = dec_r.ovf;
        resIn.zero = resultZero;
        resIn.unsafe = dec_r.unsafe;
    end

    // result valid next: a load fills the slot, a handover empties it
    always_comb begin
        resValid_nxt = resValid_r;
        if (resLoad) begin
            resValid_nxt = 1'b1;
        end else if (resReady) begin
            resValid_nxt = 1'b0;
        end
    end

    // result valid register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resValid_r <= 1'b0;
        end else begin
            resValid_r <= resValid_nxt;
        end
    end

    // result payload next: held until the next load
    always_comb begin
        res_nxt = res_r;
        if (resLoad) begin
            res_nxt = resIn;
        end
    end

    // result payload register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    // trap events: an overflowing result load sets, the clear input clears
    assign trapSet = resLoad && dec_r.ovf;
    assign trapClr = trapClear;

    // sticky trap: a new overflow wins over a clear in the same cycle
    always_comb begin
        trap_nxt = trap_r;
        if (trapClr) begin
            trap_nxt = 1'b0;
        end
        if (trapSet) begin
            trap_nxt = 1'b1;
        end
    end

    // sticky trap register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trap_r <= 1'b0;
        end else begin
            trap_r <= trap_nxt;
        end
    end

    // result handshake and payload
    assign resValid = resValid_r;
    assign res = res_r;

    // sticky status
    assign trapSticky = trap_r;
endmodule

//--- pkg/lsc_pkg.sv
package lsc_pkg;
    // operand and count geometry
    localparam int WIDTH = 32;
    localparam int CNT_W = 8;
    localparam int AMT_W = 5;
    // count that runs the full single-bit sequence and leaves the operand as it was
    localparam logic [CNT_W-1:0] FULL_COUNT = 8'h20;
    // count bit that raises overflow and overflow-trap
    localparam int OVF_BIT = 5;
    // highest count that software may use safely
    localparam logic [CNT_W-1:0] MAX_SAFE_COUNT = 8'h1F;
    // reset values
    localparam logic [WIDTH-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [AMT_W-1:0] AMT_ZERO = 5'h0;
    localparam logic [WIDTH-1:0] ZERO_FILL = 32'h0000_0000;

    // shift direction
    typedef enum logic {
        LSC_LEFT,
        LSC_RIGHT
    } lsc_dir_t;

    // request from the execution pipeline
    typedef struct packed {
        lsc_dir_t dir;
        logic [WIDTH-1:0] operand;
        logic [CNT_W-1:0] count;
    } lsc_req_t;

    // decoded request after the count has been judged
    typedef struct packed {
        lsc_dir_t dir;
        logic [WIDTH-1:0] operand;
        logic [AMT_W-1:0] amount;
        logic bypass;
        logic ovf;
        logic unsafe;
    } lsc_dec_t;

    // result towards the register file and status
    typedef struct packed {
        logic [WIDTH-1:0] data;
        logic ovf;
        logic ovfTrap;
        logic zero;
        logic unsafe;
    } lsc_res_t;
endpackage

//--- rtl/lsc_barrel.sv
module lsc_barrel (
    // operand and amount
    input wire lsc_pkg::lsc_dir_t dir,
    input wire logic [lsc_pkg::WIDTH-1:0] dataIn,
    input wire logic [lsc_pkg::AMT_W-1:0] amount,
    // shifted value
    output logic [lsc_pkg::WIDTH-1:0] dataOut
);
    import lsc_pkg::*;

    logic [WIDTH-1:0] stage [0:AMT_W];

    assign stage[0] = dataIn;

    // one logarithmic stage per amount bit, vacated bits fill with zero
    genvar g;
    generate
        for (g = 0; g < AMT_W; g++) begin : gStage
            localparam int STEP = 2 ** g;
            assign stage[g+1] = !amount[g] ? stage[g]
                : (dir == LSC_LEFT) ? {stage[g][WIDTH-1-STEP:0], ZERO_FILL[STEP-1:0]}
                : {ZERO_FILL[STEP-1:0], stage[g][WIDTH-1:STEP]};
        end
    endgenerate

    assign dataOut = stage[AMT_W];
endmodule

//--- testbench/lsc_checker_assertions.sv
module lsc_checker (
    // watched ports
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire lsc_pkg::lsc_req_t req,
    input wire logic resReady,
    input wire logic resValid,
    input wire lsc_pkg::lsc_res_t res,
    input wire logic trapSticky
);
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;
    logic [WIDTH-1:0] expL;
    logic [WIDTH-1:0] expR;
    logic [WIDTH-1:0] opnd;
    logic cBit;
    // reference values
    assign expL = req.operand << req.count[AMT_W-1:0];
    assign expR = req.operand >> req.count[AMT_W-1:0];
    assign opnd = req.operand;
    assign cBit = req.count[OVF_BIT];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // take, then a free result stage
    sequence s_go;
        reqValid && reqReady ##1 resReady;
    endsequence
    property p_left;
        req.dir == LSC_LEFT ##0 s_go |=> resValid && res.data == $past(expL, 2);
    endproperty
    a_left: assert property (p_left) else $error("left bad");
    property p_right;
        req.dir == LSC_RIGHT ##0 s_go |=> resValid && res.data == $past(expR, 2);
    endproperty
    a_right: assert property (p_right) else $error("right bad");
    property p_full;
        req.count == FULL_COUNT ##0 s_go |=> res.data == $past(opnd, 2);
    endproperty
    a_full: assert property (p_full) else $error("full bad");
    property p_ovf;
        s_go |=> res.ovf == $past(cBit, 2);
    endproperty
    a_ovf: assert property (p_ovf) else $error("ovf bad");
    property p_trap;
        s_go |=> res.ovfTrap == $past(cBit, 2);
    endproperty
    a_trap: assert property (p_trap) else $error("trap bad");
    // an overflowing result leaves the sticky trap set
    property p_sticky;
        s_go |=> $past(cBit, 2) == 1'b0 || trapSticky;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky trap not set");
endmodule
bind long_shift_count_unit lsc_checker u_lsc_checker (.clk_sys(clk_sys), .rst(rst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .resReady(resReady),
    .resValid(resValid), .res(res), .trapSticky(trapSticky));

//--- testbench/lsc_rf_model.sv
module lsc_rf_model (
    // clock, reset, acceptance
    input wire logic clk_sys,
    input wire logic rst,
    output logic resReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph;
    // stalls two cycles in eight
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph <= 3'h0;
            resReady <= 1'b0;
        end else begin
            ph <= ph + 3'h1;
            resReady <= ph[2:1] != 2'h3;
        end
    end
endmodule

//--- testbench/long_shift_count_unit_tb.sv
module long_shift_count_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0;
    logic trapClear = 1'b0;
    lsc_req_t req = '0;
    logic reqReady, resValid, resReady, trapSticky;
    lsc_res_t res;
    lsc_res_t expQ[$];
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] sd = 32'h0000_78B4;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    long_shift_count_unit u_long_shift_count_unit (.clk_sys(clk_sys), .rst(rst),
        .reqValid(reqValid), .reqReady(reqReady), .req(req), .resValid(resValid),
        .resReady(resReady), .res(res), .trapClear(trapClear), .trapSticky(trapSticky));
    lsc_rf_model u_lsc_rf_model (.clk_sys(clk_sys), .rst(rst), .resReady(resReady));
    // clock and hang guard
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    // every count once, then random ones
    initial begin
        lsc_res_t e;
        logic ok;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 400; i++) begin
            sd = xs(sd);
            req.dir <= lsc_dir_t'(sd[8]);
            req.count <= i < 256 ? i[7:0] : sd[7:0];
            trapClear <= sd[9] & sd[10];
            sd = xs(sd);
            req.operand <= sd;
            reqValid <= 1'b1;
            do begin
                @(negedge clk_sys);
                ok = reqReady;
                @(posedge clk_sys);
            end while (ok !== 1'b1);
            e.data = req.dir == LSC_LEFT ? req.operand << req.count[4:0]
                : req.operand >> req.count[4:0];
            e.ovf = req.count[5];
            e.ovfTrap = req.count[5];
            e.zero = e.data == 0;
            e.unsafe = req.count > MAX_SAFE_COUNT;
            expQ.push_back(e);
        end
        reqValid <= 1'b0;
        repeat (20) @(posedge clk_sys);
        if (expQ.size() != 0) failures++;
        wrap_up();
    end
    // result monitor
    always @(negedge clk_sys) begin
        if (!rst && resValid === 1'b1 && resReady === 1'b1) begin
            if (expQ.size() == 0) failures++;
            else check(64'(res), 64'(expQ.pop_front()));
        end
    end
    // trap model: decode slot occupancy, an overflowing load sets, a clear alone clears
    logic mDec = 1'b0;
    logic mDecOvf = 1'b0;
    logic mTrap = 1'b0;
    logic mLoad;
    always @(negedge clk_sys) begin
        if (rst) begin
            mDec = 1'b0;
            mTrap = 1'b0;
        end else begin
            check(64'(trapSticky), 64'(mTrap));
            mLoad = mDec && (resValid !== 1'b1 || resReady === 1'b1);
            if (trapClear === 1'b1) mTrap = 1'b0;
            if (mLoad && mDecOvf) mTrap = 1'b1;
            if (reqValid === 1'b1 && reqReady === 1'b1) begin
                mDec = 1'b1;
                mDecOvf = req.count[OVF_BIT];
            end else if (mLoad) begin
                mDec = 1'b0;
            end
        end
    end
endmodule
